// ===== inc/dam_defines.svh
// constants for the accumulator and multiplier datapath
`ifndef DAM_DEFINES_SVH
`define DAM_DEFINES_SVH

// operand placement
`define DAM_HIGH_SHIFT     16
`define DAM_ROUND_CONST    32'h0000_8000
`define DAM_LOGIC_MASK     32'h7FFF_FFFF

// register byte addresses on the AXI4-Lite port
`define DAM_REG_SUM        8'h00
`define DAM_REG_PROD       8'h04
`define DAM_REG_STATUS     8'h08
`define DAM_REG_CTRL       8'h0C
`define DAM_REG_MULT       8'h10
`define DAM_REG_AUX_BASE   8'h20
`define DAM_REG_AUX_LAST   8'h3C

// status word fields
`define DAM_ST_CARRY       0
`define DAM_ST_TEST        1
`define DAM_ST_PTR_LO      2
`define DAM_ST_BUF_LO      5
`define DAM_ST_SHIFT_LO    8
`define DAM_ST_PAGE_LO     16

// control word fields and reset value
`define DAM_CT_CMP_LO      0
`define DAM_CT_SXM         2
`define DAM_CTRL_RESET     3'h0

// bus responses
`define DAM_RESP_OKAY      2'h0
`define DAM_RESP_SLVERR    2'h2

`endif

// ===== inc/dam_pkg.sv
// types for the accumulator and multiplier datapath
package dam_pkg;

  // decoded operations presented by the instruction sequencer
  typedef enum logic [4:0] {
    DAM_NOP              = 5'h00,
    DAM_ADD_WITH_CARRY   = 5'h01,
    DAM_SUB_WITH_BORROW  = 5'h02,
    DAM_ADD_UPPER_HALF   = 5'h03,
    DAM_SUB_UPPER_HALF   = 5'h04,
    DAM_ADD_UNSIGNED_LOW = 5'h05,
    DAM_SUB_UNSIGNED_LOW = 5'h06,
    DAM_ADD_SHORT_IMM    = 5'h07,
    DAM_SUB_SHORT_IMM    = 5'h08,
    DAM_AND_LONG_IMM     = 5'h09,
    DAM_OR_LONG_IMM      = 5'h0A,
    DAM_XOR_LONG_IMM     = 5'h0B,
    DAM_SUB_LONG_IMM     = 5'h0C,
    DAM_CLR_LOAD_HI_RND  = 5'h0D,
    DAM_CLR_LOAD_LOW     = 5'h0E,
    DAM_AUX_COMPARE      = 5'h0F,
    DAM_LOAD_AUX_POINTER = 5'h10,
    DAM_LOAD_PAGE_IMM    = 5'h11,
    DAM_AUX_ADD_IMM      = 5'h12,
    DAM_AUX_SUB_IMM      = 5'h13,
    DAM_LOAD_OPND_ACCUM  = 5'h14,
    DAM_LOAD_ACCUM_MOVE  = 5'h15,
    DAM_MULTIPLY_SUB     = 5'h16,
    DAM_MUL_ACCUM_MOVE   = 5'h17,
    DAM_SQUARE_SUB       = 5'h18,
    DAM_SET_PROD_SHIFT   = 5'h19,
    DAM_STORE_PROD_HIGH  = 5'h1A,
    DAM_STORE_PROD_LOW   = 5'h1B,
    DAM_LOAD_AUX_REG     = 5'h1C
  } dam_op_t;

  // compare conditions of the auxiliary compare
  typedef enum logic [1:0] {
    DAM_CMP_EQ = 2'h0,
    DAM_CMP_LT = 2'h1,
    DAM_CMP_GT = 2'h2,
    DAM_CMP_NE = 2'h3
  } dam_cmp_t;

endpackage

// ===== core/dam_datapath.sv
// accumulator, auxiliary register and multiplier datapath
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "dam_defines.svh"

module dam_datapath
  import dam_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  // decoded operation from the sequencer
  input  wire logic        OP_VALID_I,
  input  wire dam_op_t     OP_CODE_I,
  input  wire logic [15:0] OP_DATA_I,
  input  wire logic [15:0] OP_DATA2_I,
  input  wire logic [15:0] OP_IMM_I,
  input  wire logic [3:0]  OP_SHIFT_I,
  // results back to data memory
  output logic             MEM_WR_O,
  output logic             MEM_MOVE_O,
  output logic [15:0]      MEM_DATA_O,
  // AXI4-Lite register port
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I
);

  logic [31:0] sum_ff;
  logic [31:0] prod_ff;
  logic [15:0] mult_ff;
  logic        carry_ff;
  logic        test_flag_ff;
  logic [2:0]  aux_pointer_ff;
  logic [2:0]  aux_pointer_buffer_ff;
  logic [8:0]  page_pointer_ff;
  logic [1:0]  product_shift_field_ff;
  logic [15:0] aux_ff [0:7];
  logic [2:0]  ctrl_ff;
  logic [31:0] nxt_sum;
  logic        nxt_carry;
  logic [31:0] shifted_prod;
  logic [31:0] alu_b;
  logic        alu_sub;
  logic        alu_cin;
  logic        alu_use;
  logic [32:0] alu_out;
  logic [31:0] data_ext;
  logic [31:0] imm_shifted;
  logic [15:0] selected_aux_reg;
  logic        cmp_hit;
  logic        op_go;
  dam_cmp_t    compare_select;
  logic        sxm;

  assign op_go          = OP_VALID_I;
  assign compare_select = dam_cmp_t'(ctrl_ff[`DAM_CT_CMP_LO +: 2]);
  assign sxm            = ctrl_ff[`DAM_CT_SXM];
  assign selected_aux_reg = aux_ff[aux_pointer_ff];

  // product output shifter
  always_comb begin
    case (product_shift_field_ff)
      2'h0:    shifted_prod = prod_ff;
      2'h1:    shifted_prod = {prod_ff[30:0], 1'b0};
      2'h2:    shifted_prod = {prod_ff[27:0], 4'h0};
      default: shifted_prod = {{6{prod_ff[31]}}, prod_ff[31:6]};
    endcase
  end

  // operand extension by sign-extension mode, and scaled long constant
  always_comb begin
    data_ext    = sxm ? {{16{OP_DATA_I[15]}}, OP_DATA_I}
                      : {16'h0000, OP_DATA_I};
    imm_shifted = (sxm ? {{16{OP_IMM_I[15]}}, OP_IMM_I}
                       : {16'h0000, OP_IMM_I}) << OP_SHIFT_I;
  end

  // selection of the second ALU input
  always_comb begin
    alu_b   = 32'h0000_0000;
    alu_sub = 1'b0;
    alu_cin = 1'b0;
    alu_use = 1'b1;
    case (OP_CODE_I)
      DAM_ADD_WITH_CARRY: begin
        alu_b   = data_ext;
        alu_cin = carry_ff;
      end
      DAM_SUB_WITH_BORROW: begin
        alu_b   = data_ext;
        alu_sub = 1'b1;
        alu_cin = carry_ff;
      end
      DAM_ADD_UPPER_HALF: alu_b = {OP_DATA_I, 16'h0000};
      DAM_SUB_UPPER_HALF: begin
        alu_b   = {OP_DATA_I, 16'h0000};
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      DAM_ADD_UNSIGNED_LOW: alu_b = {16'h0000, OP_DATA_I};
      DAM_SUB_UNSIGNED_LOW: begin
        alu_b   = {16'h0000, OP_DATA_I};
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      DAM_ADD_SHORT_IMM: alu_b = {24'h000000, OP_IMM_I[7:0]};
      DAM_SUB_SHORT_IMM: begin
        alu_b   = {24'h000000, OP_IMM_I[7:0]};
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      DAM_SUB_LONG_IMM: begin
        alu_b   = imm_shifted;
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      DAM_LOAD_OPND_ACCUM, DAM_LOAD_ACCUM_MOVE, DAM_MUL_ACCUM_MOVE:
        alu_b = shifted_prod;
      DAM_MULTIPLY_SUB, DAM_SQUARE_SUB: begin
        alu_b   = shifted_prod;
        alu_sub = 1'b1;
        alu_cin = 1'b1;
      end
      default: alu_use = 1'b0;
    endcase
  end

  // carry out doubles as the not-borrow of a subtraction
  assign alu_out = {1'b0, sum_ff} + {1'b0, alu_sub ? ~alu_b : alu_b}
                 + {32'h0000_0000, alu_cin};

  // next accumulator value
  always_comb begin
    nxt_sum   = sum_ff;
    nxt_carry = carry_ff;
    if (op_go && alu_use) begin
      nxt_sum   = alu_out[31:0];
      nxt_carry = alu_out[32];
    end else if (op_go) begin
      case (OP_CODE_I)
        DAM_AND_LONG_IMM:
          nxt_sum = (sum_ff & ~`DAM_LOGIC_MASK)
                  | (sum_ff & imm_shifted & `DAM_LOGIC_MASK);
        DAM_OR_LONG_IMM:
          nxt_sum = sum_ff | (imm_shifted & `DAM_LOGIC_MASK);
        DAM_XOR_LONG_IMM:
          nxt_sum = sum_ff ^ (imm_shifted & `DAM_LOGIC_MASK);
        DAM_CLR_LOAD_HI_RND:
          nxt_sum = {OP_DATA_I, 16'h0000} + `DAM_ROUND_CONST;
        DAM_CLR_LOAD_LOW:
          nxt_sum = {16'h0000, OP_DATA_I};
        default: nxt_sum = sum_ff;
      endcase
    end
  end

  // auxiliary compare condition, unsigned
  always_comb begin
    case (compare_select)
      DAM_CMP_EQ: cmp_hit = (selected_aux_reg == aux_ff[0]);
      DAM_CMP_LT: cmp_hit = (selected_aux_reg <  aux_ff[0]);
      DAM_CMP_GT: cmp_hit = (selected_aux_reg >  aux_ff[0]);
      default:    cmp_hit = (selected_aux_reg != aux_ff[0]);
    endcase
  end

  // accumulator and carry
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      sum_ff   <= 32'h0000_0000;
      carry_ff <= 1'b0;
    end else begin
      sum_ff   <= nxt_sum;
      carry_ff <= nxt_carry;
    end
  end

  // multiplier operand and product
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      prod_ff <= 32'h0000_0000;
      mult_ff <= 16'h0000;
    end else if (op_go) begin
      case (OP_CODE_I)
        DAM_LOAD_OPND_ACCUM, DAM_LOAD_ACCUM_MOVE:
          mult_ff <= OP_DATA_I;
        DAM_MULTIPLY_SUB:
          prod_ff <= $signed(mult_ff) * $signed(OP_DATA_I);
        DAM_MUL_ACCUM_MOVE:
          prod_ff <= $signed(OP_DATA2_I) * $signed(OP_DATA_I);
        DAM_SQUARE_SUB:
          prod_ff <= $signed(OP_DATA_I) * $signed(OP_DATA_I);
        default: prod_ff <= prod_ff;
      endcase
    end
  end

  // test flag, pointers, page and product shift field
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      test_flag_ff          <= 1'b0;
      aux_pointer_ff        <= 3'h0;
      aux_pointer_buffer_ff <= 3'h0;
      page_pointer_ff       <= 9'h000;
      product_shift_field_ff <= 2'h0;
    end else if (op_go) begin
      case (OP_CODE_I)
        DAM_AUX_COMPARE: test_flag_ff <= cmp_hit;
        DAM_LOAD_AUX_POINTER: begin
          aux_pointer_ff        <= OP_IMM_I[2:0];
          aux_pointer_buffer_ff <= aux_pointer_ff;
        end
        DAM_LOAD_PAGE_IMM: page_pointer_ff <= OP_IMM_I[8:0];
        DAM_SET_PROD_SHIFT:
          product_shift_field_ff <= OP_IMM_I[1:0];
        default: test_flag_ff <= test_flag_ff;
      endcase
    end
  end

  // auxiliary register file, 16-bit unsigned wrap-around
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < 8; i++) begin
        aux_ff[i] <= 16'h0000;
      end
    end else if (op_go) begin
      case (OP_CODE_I)
        DAM_AUX_ADD_IMM:
          aux_ff[aux_pointer_ff] <= selected_aux_reg
                                  + {8'h00, OP_IMM_I[7:0]};
        DAM_AUX_SUB_IMM:
          aux_ff[aux_pointer_ff] <= selected_aux_reg
                                  - {8'h00, OP_IMM_I[7:0]};
        DAM_LOAD_AUX_REG: aux_ff[aux_pointer_ff] <= OP_DATA_I;
        default: aux_ff[aux_pointer_ff] <= selected_aux_reg;
      endcase
    end
  end

  // results to data memory: product stores and upward data moves
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      MEM_WR_O   <= 1'b0;
      MEM_MOVE_O <= 1'b0;
      MEM_DATA_O <= 16'h0000;
    end else begin
      MEM_WR_O   <= op_go && (OP_CODE_I == DAM_STORE_PROD_HIGH ||
                              OP_CODE_I == DAM_STORE_PROD_LOW);
      MEM_MOVE_O <= op_go && (OP_CODE_I == DAM_LOAD_ACCUM_MOVE ||
                              OP_CODE_I == DAM_MUL_ACCUM_MOVE);
      if (op_go && OP_CODE_I == DAM_STORE_PROD_HIGH) begin
        MEM_DATA_O <= shifted_prod[31:16];
      end else if (op_go && OP_CODE_I == DAM_STORE_PROD_LOW) begin
        MEM_DATA_O <= shifted_prod[15:0];
      end else begin
        MEM_DATA_O <= OP_DATA_I;
      end
    end
  end

  // bus write: address and data taken together, then one response
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      S_AXI_BVALID_O  <= 1'b0;
      S_AXI_BRESP_O   <= `DAM_RESP_OKAY;
      ctrl_ff         <= `DAM_CTRL_RESET;
    end else begin
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
      if (S_AXI_AWVALID_I && S_AXI_WVALID_I && !S_AXI_AWREADY_O &&
          !S_AXI_BVALID_O) begin
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O  <= 1'b1;
        S_AXI_BVALID_O  <= 1'b1;
        if (S_AXI_AWADDR_I == `DAM_REG_CTRL) begin
          S_AXI_BRESP_O <= `DAM_RESP_OKAY;
          if (S_AXI_WSTRB_I[0]) begin
            ctrl_ff <= S_AXI_WDATA_I[2:0];
          end
        end else begin
          S_AXI_BRESP_O <= `DAM_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // bus read: state and registers of the datapath
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= `DAM_RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= 1'b0;
      if (S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O) begin
        S_AXI_ARREADY_O <= 1'b1;
        S_AXI_RVALID_O  <= 1'b1;
        S_AXI_RRESP_O   <= `DAM_RESP_OKAY;
        S_AXI_RDATA_O   <= 32'h0000_0000;
        case (S_AXI_ARADDR_I)
          `DAM_REG_SUM:  S_AXI_RDATA_O <= sum_ff;
          `DAM_REG_PROD: S_AXI_RDATA_O <= prod_ff;
          `DAM_REG_MULT: S_AXI_RDATA_O <= {16'h0000, mult_ff};
          `DAM_REG_CTRL: S_AXI_RDATA_O <= {29'h0, ctrl_ff};
          `DAM_REG_STATUS: begin
            S_AXI_RDATA_O[`DAM_ST_CARRY]         <= carry_ff;
            S_AXI_RDATA_O[`DAM_ST_TEST]          <= test_flag_ff;
            S_AXI_RDATA_O[`DAM_ST_PTR_LO +: 3]   <= aux_pointer_ff;
            S_AXI_RDATA_O[`DAM_ST_BUF_LO +: 3]   <= aux_pointer_buffer_ff;
            S_AXI_RDATA_O[`DAM_ST_SHIFT_LO +: 2] <= product_shift_field_ff;
            S_AXI_RDATA_O[`DAM_ST_PAGE_LO +: 9]  <= page_pointer_ff;
          end
          default: begin
            if (S_AXI_ARADDR_I >= `DAM_REG_AUX_BASE &&
                S_AXI_ARADDR_I <= `DAM_REG_AUX_LAST &&
                S_AXI_ARADDR_I[1:0] == 2'h0) begin
              S_AXI_RDATA_O <= {16'h0000, aux_ff[S_AXI_ARADDR_I[4:2]]};
            end else begin
              S_AXI_RRESP_O <= `DAM_RESP_SLVERR;
            end
          end
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // checks
  default clocking dam_cb @(posedge MCLK_I);
  endclocking
  default disable iff (SRST_I);

  chk_carry_add: assert property (
    op_go && OP_CODE_I == DAM_ADD_WITH_CARRY |=>
    sum_ff == 32'($past(sum_ff)
                  + {{16{$past(sxm && OP_DATA_I[15])}}, $past(OP_DATA_I)}
                  + {31'h0, $past(carry_ff)}))
    else $error("add with carry result wrong");
  chk_borrow_sub: assert property (
    op_go && OP_CODE_I == DAM_SUB_WITH_BORROW |=>
    sum_ff == 32'($past(sum_ff)
                  - {{16{$past(sxm && OP_DATA_I[15])}}, $past(OP_DATA_I)}
                  - {31'h0, !$past(carry_ff)}))
    else $error("subtract with borrow result wrong");
  chk_round_load: assert property (
    op_go && OP_CODE_I == DAM_CLR_LOAD_HI_RND |=>
    sum_ff == {$past(OP_DATA_I), 16'h8000})
    else $error("rounded high load wrong");
  chk_low_load: assert property (
    op_go && OP_CODE_I == DAM_CLR_LOAD_LOW |=>
    sum_ff[31:16] == 16'h0000 && sum_ff[15:0] == $past(OP_DATA_I))
    else $error("low load wrong");
  chk_ptr_swap: assert property (
    op_go && OP_CODE_I == DAM_LOAD_AUX_POINTER |=>
    aux_pointer_buffer_ff == $past(aux_pointer_ff) &&
    aux_pointer_ff == $past(OP_IMM_I[2:0]))
    else $error("pointer load wrong");
  chk_page_load: assert property (
    op_go && OP_CODE_I == DAM_LOAD_PAGE_IMM |=>
    page_pointer_ff == $past(OP_IMM_I[8:0]))
    else $error("page load wrong");
  chk_square_prod: assert property (
    op_go && OP_CODE_I == DAM_SQUARE_SUB |=>
    $signed(prod_ff) == $signed($past(OP_DATA_I)) *
                        $signed($past(OP_DATA_I)))
    else $error("square product wrong");
  chk_store_high: assert property (
    op_go && OP_CODE_I == DAM_STORE_PROD_HIGH |=>
    MEM_WR_O && MEM_DATA_O == $past(shifted_prod[31:16]))
    else $error("product high store wrong");
  chk_reset_zero: assert property (
    disable iff (1'b0) SRST_I |=>
    sum_ff == 32'h0 && prod_ff == 32'h0 && !carry_ff && !test_flag_ff)
    else $error("reset did not clear state");

endmodule

// ===== verification/dam_seq_model.sv
// sequencer model presenting one decoded operation per call
`timescale 1ns/10ps
module dam_seq_model
  import dam_pkg::*;
(
  // clock
  input  wire logic   clk_i,
  // decoded operation towards the datapath
  output logic        op_valid_o,
  output dam_op_t     op_code_o,
  output logic [15:0] op_data_o,
  output logic [15:0] op_data2_o,
  output logic [15:0] op_imm_o,
  output logic [3:0]  op_shift_o
);
  // quiet lines at time zero
  initial begin
    op_valid_o = 1'b0;
    op_code_o  = DAM_NOP;
    {op_data_o, op_data2_o, op_imm_o, op_shift_o} = 52'h0;
  end

  // hold everything across one sampling edge, then scramble the released
  // lines so a stale operand can never pass for a fresh one
  task automatic issue(input dam_op_t c, input logic [15:0] d, d2, imm,
                       input logic [3:0] sh);
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_code_o  <= c;
    op_data_o  <= d;
    op_data2_o <= d2;
    op_imm_o   <= imm;
    op_shift_o <= sh;
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    op_code_o  <= DAM_NOP;
    {op_data_o, op_data2_o, op_imm_o, op_shift_o} <= ~{d, d2, imm, sh};
  endtask
endmodule

// ===== verification/tb.sv
// self-checking bench for the accumulator and multiplier datapath
`timescale 1ns/10ps
`include "dam_defines.svh"
module tb
  import dam_pkg::*;
;
  logic        clk, srst, op_v, mem_wr, mem_mv;
  dam_op_t     op_c;
  logic [15:0] op_d, op_d2, op_imm, mem_d;
  logic [3:0]  op_sh, wstrb;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // device under test, write strobes driven by the bench
  dam_datapath dut_u (
    .MCLK_I(clk), .SRST_I(srst), .OP_VALID_I(op_v), .OP_CODE_I(op_c),
    .OP_DATA_I(op_d), .OP_DATA2_I(op_d2), .OP_IMM_I(op_imm),
    .OP_SHIFT_I(op_sh), .MEM_WR_O(mem_wr), .MEM_MOVE_O(mem_mv),
    .MEM_DATA_O(mem_d), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
  );

  // instruction sequencer
  dam_seq_model seq_u (
    .clk_i(clk), .op_valid_o(op_v), .op_code_o(op_c), .op_data_o(op_d),
    .op_data2_o(op_d2), .op_imm_o(op_imm), .op_shift_o(op_sh)
  );

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // register write, address and data offered together; response in r
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready === 1'b1) aw_ok = 1'b1;
      if (wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask

  // register read; data in v, response in r
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    check(v, e);
  endtask

  task automatic op(input dam_op_t c, input logic [15:0] d, imm);
    seq_u.issue(c, d, 16'h0, imm, 4'h0);
  endtask

  // one operation, then the sum register against its expected value
  task automatic opsum(input dam_op_t c, input logic [15:0] d, imm,
                       input logic [31:0] e);
    op(c, d, imm);
    rd_chk(`DAM_REG_SUM, e);
  endtask

  // long immediate operation with a coded shift
  task automatic lsum(input dam_op_t c, input logic [15:0] imm,
                      input logic [3:0] sh, input logic [31:0] e);
    seq_u.issue(c, 16'h0, 16'h0, imm, sh);
    rd_chk(`DAM_REG_SUM, e);
  endtask

  // store strobes and data 1 ns after the edge that took the operation
  task automatic mem_chk(input logic wr, mv, input logic [15:0] d);
    #1;
    check({14'h0, mem_wr, mem_mv, mem_d}, {14'h0, wr, mv, d});
  endtask

  // aux compare under one condition, then the test flag
  task automatic cmp_chk(input dam_cmp_t s, input logic e);
    axi_wr(`DAM_REG_CTRL, {30'h0, s});
    op(DAM_AUX_COMPARE, 16'h0, 16'h0);
    axi_rd(`DAM_REG_STATUS);
    check({31'h0, v[`DAM_ST_TEST]}, {31'h0, e});
  endtask

  // pointer buffer and pointer fields of the status word
  task automatic st_chk(input logic [2:0] p, b);
    axi_rd(`DAM_REG_STATUS);
    check({26'h0, v[7:2]}, {26'h0, b, p});
  endtask

  // cycle ceiling against a hung handshake
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  // main sequence
  initial begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd_chk(`DAM_REG_SUM, 32'h0);
    rd_chk(`DAM_REG_PROD, 32'h0);
    rd_chk(`DAM_REG_STATUS, 32'h0);
    axi_rd(8'h14);
    check({30'h0, r}, {30'h0, `DAM_RESP_SLVERR});
    axi_wr(`DAM_REG_SUM, 32'h1);
    check({30'h0, r}, {30'h0, `DAM_RESP_SLVERR});
    axi_wr(`DAM_REG_CTRL, 32'h4);
    rd_chk(`DAM_REG_CTRL, 32'h4);
    wstrb <= 4'hE;
    axi_wr(`DAM_REG_CTRL, 32'h0);
    wstrb <= 4'hF;
    rd_chk(`DAM_REG_CTRL, 32'h4);
    $display("test reset and bus done");
    // sign extension on: low-half ops must still zero-extend
    opsum(DAM_CLR_LOAD_LOW, 16'h8001, 16'h0, 32'h0000_8001);
    opsum(DAM_CLR_LOAD_HI_RND, 16'hFFFF, 16'h0, 32'hFFFF_8000);
    opsum(DAM_ADD_UNSIGNED_LOW, 16'h8000, 16'h0, 32'h0);
    opsum(DAM_ADD_WITH_CARRY, 16'h0005, 16'h0, 32'h6);
    opsum(DAM_SUB_WITH_BORROW, 16'h0002, 16'h0, 32'h3);
    opsum(DAM_SUB_WITH_BORROW, 16'h0004, 16'h0, 32'hFFFF_FFFF);
    opsum(DAM_ADD_WITH_CARRY, 16'h0001, 16'h0, 32'h0);
    opsum(DAM_SUB_UNSIGNED_LOW, 16'hFFFF, 16'h0, 32'hFFFF_0001);
    opsum(DAM_SUB_UPPER_HALF, 16'h0001, 16'h0, 32'hFFFE_0001);
    opsum(DAM_ADD_UPPER_HALF, 16'h0003, 16'h0, 32'h0001_0001);
    axi_wr(`DAM_REG_CTRL, 32'h0);
    opsum(DAM_ADD_SHORT_IMM, 16'h0, 16'h01FF, 32'h0001_0100);
    opsum(DAM_SUB_SHORT_IMM, 16'h0, 16'h010F, 32'h0001_00F1);
    lsum(DAM_SUB_LONG_IMM, 16'h0010, 4'h4, 32'h0000_FFF1);
    opsum(DAM_CLR_LOAD_HI_RND, 16'h8123, 16'h0, 32'h8123_8000);
    lsum(DAM_AND_LONG_IMM, 16'hFFF0, 4'h8, 32'h8023_8000);
    lsum(DAM_OR_LONG_IMM, 16'h000F, 4'h0, 32'h8023_800F);
    lsum(DAM_XOR_LONG_IMM, 16'hFFFF, 4'hF, 32'hFFDC_000F);
    $display("test sum ops done");
    op(DAM_LOAD_AUX_POINTER, 16'h0, 16'h0);
    op(DAM_LOAD_AUX_REG, 16'h0100, 16'h0);
    op(DAM_LOAD_AUX_POINTER, 16'h0, 16'h0003);
    st_chk(3'h3, 3'h0);
    op(DAM_LOAD_AUX_REG, 16'h0010, 16'h0);
    op(DAM_AUX_ADD_IMM, 16'h0, 16'h01F0);
    rd_chk(`DAM_REG_AUX_BASE + 8'h0C, 32'h0100);
    cmp_chk(DAM_CMP_EQ, 1'b1);
    cmp_chk(DAM_CMP_LT, 1'b0);
    op(DAM_AUX_SUB_IMM, 16'h0, 16'h0001);
    cmp_chk(DAM_CMP_LT, 1'b1);
    cmp_chk(DAM_CMP_GT, 1'b0);
    cmp_chk(DAM_CMP_NE, 1'b1);
    cmp_chk(DAM_CMP_EQ, 1'b0);
    op(DAM_AUX_SUB_IMM, 16'h0, 16'h00FF);
    op(DAM_AUX_SUB_IMM, 16'h0, 16'h0001);
    rd_chk(`DAM_REG_AUX_BASE + 8'h0C, 32'hFFFF);
    op(DAM_LOAD_AUX_POINTER, 16'h0, 16'h0005);
    st_chk(3'h5, 3'h3);
    op(DAM_LOAD_PAGE_IMM, 16'h0, 16'h03FF);
    axi_rd(`DAM_REG_STATUS);
    check({23'h0, v[24:16]}, 32'h01FF);
    $display("test aux ops done");
    op(DAM_SET_PROD_SHIFT, 16'h0, 16'h0);
    op(DAM_CLR_LOAD_LOW, 16'h0, 16'h0);
    op(DAM_LOAD_OPND_ACCUM, 16'h0003, 16'h0);
    opsum(DAM_MULTIPLY_SUB, 16'hFFFE, 16'h0, 32'h0);
    rd_chk(`DAM_REG_PROD, 32'hFFFF_FFFA);
    opsum(DAM_LOAD_OPND_ACCUM, 16'h0004, 16'h0, 32'hFFFF_FFFA);
    rd_chk(`DAM_REG_MULT, 32'h0004);
    op(DAM_SET_PROD_SHIFT, 16'h0, 16'h0001);
    op(DAM_STORE_PROD_HIGH, 16'h0, 16'h0);
    mem_chk(1'b1, 1'b0, 16'hFFFF);
    op(DAM_STORE_PROD_LOW, 16'h0, 16'h0);
    mem_chk(1'b1, 1'b0, 16'hFFF4);
    opsum(DAM_SQUARE_SUB, 16'h0100, 16'h0, 32'h6);
    rd_chk(`DAM_REG_PROD, 32'h0001_0000);
    op(DAM_SET_PROD_SHIFT, 16'h0, 16'h0002);
    op(DAM_STORE_PROD_HIGH, 16'h0, 16'h0);
    mem_chk(1'b1, 1'b0, 16'h0010);
    op(DAM_SET_PROD_SHIFT, 16'h0, 16'h0003);
    op(DAM_STORE_PROD_LOW, 16'h0, 16'h0);
    mem_chk(1'b1, 1'b0, 16'h0400);
    seq_u.issue(DAM_MUL_ACCUM_MOVE, 16'h0002, 16'h0003, 16'h0, 4'h0);
    mem_chk(1'b0, 1'b1, 16'h0002);
    rd_chk(`DAM_REG_SUM, 32'h0406);
    rd_chk(`DAM_REG_PROD, 32'h0006);
    op(DAM_SET_PROD_SHIFT, 16'h0, 16'h0);
    op(DAM_LOAD_ACCUM_MOVE, 16'h0007, 16'h0);
    mem_chk(1'b0, 1'b1, 16'h0007);
    rd_chk(`DAM_REG_SUM, 32'h040C);
    rd_chk(`DAM_REG_MULT, 32'h0007);
    $display("test product ops done");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk(`DAM_REG_SUM, 32'h0);
    rd_chk(`DAM_REG_PROD, 32'h0);
    $display("test second reset done");
    final_report();
  end
endmodule
